/* File: ipf_defines.svh */
// Constants for the interrupt priority field block
`ifndef IPF_DEFINES_SVH
`define IPF_DEFINES_SVH

`define IPF_ADDR_W        4
`define IPF_DATA_W        16
`define IPF_NSRC          22
`define IPF_NSLOT         24
`define IPF_LVL_W         3
`define IPF_SRC_W         5
`define IPF_HI_W          6
`define IPF_LO_W          16
`define IPF_FIELD_PITCH   4
`define IPF_SLOTS_PER_REG 4
`define IPF_RST_LEVEL     3'h4
`define IPF_LEVEL_OFF     3'h0
`define IPF_LEVEL_MAX     3'h7
`define IPF_LEVEL_MIN     3'h1
`define IPF_SLOT_IMPL     24'hFFFB7F
`define IPF_OFS_PRIO2     4'h2
`define IPF_OFS_PRIO3     4'h3
`define IPF_OFS_PRIO4     4'h4
`define IPF_OFS_PRIO5     4'h5
`define IPF_OFS_PRIO6     4'h6
`define IPF_OFS_PRIO7     4'h7
`define IPF_OFS_STAT_LO   4'h8
`define IPF_OFS_STAT_HI   4'h9
`define IPF_OFS_CLR_LO    4'hA
`define IPF_OFS_CLR_HI    4'hB
`define IPF_OFS_EN_LO     4'hC
`define IPF_OFS_EN_HI     4'hD
`define IPF_FLD_HI        14
`define IPF_FLD_MID_HI    10
`define IPF_FLD_MID_LO    6
`define IPF_FLD_LO        2

`endif

/* File: ipf_pkg.sv */
// Types for the interrupt priority field block
`include "ipf_defines.svh"

package ipf_pkg;

  typedef enum logic [`IPF_SRC_W-1:0] {
    SRC_TIMER3 = 5'h00, SRC_SPI1_ERROR = 5'h01, SRC_SPI1_EVENT = 5'h02, SRC_UART1_RECEIVE = 5'h03,
    SRC_UART1_TRANSMIT = 5'h04, SRC_ADC1_DONE = 5'h05, SRC_DMA1_DONE = 5'h06, SRC_I2C1_SLAVE = 5'h07,
    SRC_I2C1_MASTER = 5'h08, SRC_CHANGE_NOTIFY = 5'h09, SRC_EXT_IRQ1 = 5'h0A, SRC_ADC2_DONE = 5'h0B,
    SRC_CAPTURE7 = 5'h0C, SRC_CAPTURE8 = 5'h0D, SRC_DMA2_DONE = 5'h0E, SRC_COMPARE3 = 5'h0F,
    SRC_COMPARE4 = 5'h10, SRC_TIMER4 = 5'h11, SRC_TIMER5 = 5'h12, SRC_EXT_IRQ2 = 5'h13,
    SRC_UART2_RECEIVE = 5'h14, SRC_UART2_TRANSMIT = 5'h15
  } ipf_src_t;

  typedef logic [`IPF_NSRC-1:0][`IPF_LVL_W-1:0] ipf_levels_t;

  typedef struct packed {
    logic                  valid;
    logic [`IPF_SRC_W-1:0] src;
    logic [`IPF_LVL_W-1:0] level;
  } ipf_grant_t;

  typedef struct packed {
    logic [`IPF_NSLOT-1:0][`IPF_LVL_W-1:0] prio;
    logic [`IPF_NSRC-1:0]                  flag;
    logic [`IPF_NSRC-1:0]                  enab;
    logic [`IPF_DATA_W-1:0]                rdata;
    ipf_grant_t                            grant;
  } ipf_state_t;

endpackage

/* File: ipf_priority_fields.sv */
// Interrupt priority field registers, request flags, enables and priority arbitration
// Summary of operation
// - Each source has a 3-bit level; code 111 is level 7, the highest.
// - Code 001 is level 1, lowest active; codes between rank in binary order.
// - Level 000 disables its source; it never raises the request output.
// - Bits without a priority field, including 15, 11, 7 and 3, read zero.
// - Reset loads every implemented field with 100, level 4.
// - Every implemented field is read/write and reads back the last written value.
// - Register 2: uart1 receive 14-12, spi1 event 10-8, spi1 error 6-4, timer3 2-0.
// - Register 3: 15-11 unused, dma1 done 10-8, adc1 done 6-4, uart1 transmit 2-0.
// - Register 4: change notify 14-12, 11-7 unused, i2c1 master 6-4, slave 2-0.
// - Register 5: capture8 14-12, capture7 10-8, adc2 done 6-4, ext irq1 2-0.
// - Register 6: timer4 14-12, compare4 10-8, compare3 6-4, dma2 done 2-0.
// - Register 7: uart2 transmit 14-12, uart2 receive 10-8, ext irq2 6-4, timer5 2-0.
// - A source raises a request only while its enable bit is one.
`timescale 1ns/1ps
`include "ipf_defines.svh"

module ipf_priority_fields (
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       ce,
  input  wire logic [`IPF_ADDR_W-1:0]     addr,
  input  wire logic [`IPF_DATA_W-1:0]     wdata,
  input  wire logic                       wrStb,
  input  wire logic                       rdStb,
  output logic      [`IPF_DATA_W-1:0]     rdata,
  input  wire logic [`IPF_NSRC-1:0]       srcEvent,
  output ipf_pkg::ipf_levels_t            srcLevel,
  output ipf_pkg::ipf_grant_t             grant,
  output logic                            irqOut
);

  // Source index to slot: slots 7 and 10 are the two unused field positions
  function automatic int srcSlot(input int i);
    if (i < 7) begin
      return i;
    end else if (i < 9) begin
      return i + 1;
    end else begin
      return i + 2;
    end
  endfunction

  function automatic logic [`IPF_ADDR_W-1:0] slotReg(input int s);
    return `IPF_OFS_PRIO2 + `IPF_ADDR_W'(s / `IPF_SLOTS_PER_REG);
  endfunction

  function automatic int slotPos(input int s);
    return (s % `IPF_SLOTS_PER_REG) * `IPF_FIELD_PITCH;
  endfunction

  function automatic ipf_pkg::ipf_state_t resetState();
    ipf_pkg::ipf_state_t r;
    r = '0;
    for (int s = 0; s < `IPF_NSLOT; s++) begin
      logic [`IPF_NSLOT-1:0] impl;
      impl = `IPF_SLOT_IMPL;
      r.prio[s] = impl[s] ? `IPF_RST_LEVEL : `IPF_LEVEL_OFF;
    end
    return r;
  endfunction

  // Register read mux; unused field bits and gaps stay zero
  function automatic logic [`IPF_DATA_W-1:0] readMux(input ipf_pkg::ipf_state_t st,
                                                     input logic [`IPF_ADDR_W-1:0] a);
    logic [`IPF_DATA_W-1:0] d;
    logic [`IPF_NSLOT-1:0]  impl;
    d = '0;
    impl = `IPF_SLOT_IMPL;
    for (int s = 0; s < `IPF_NSLOT; s++) begin
      if (impl[s] && a == slotReg(s)) begin
        d[slotPos(s) +: `IPF_LVL_W] = st.prio[s];
      end
    end
    case (a)
      `IPF_OFS_STAT_LO: d = st.flag[`IPF_LO_W-1:0];
      `IPF_OFS_STAT_HI: d = {{(`IPF_DATA_W-`IPF_HI_W){1'b0}}, st.flag[`IPF_NSRC-1:`IPF_LO_W]};
      `IPF_OFS_EN_LO:   d = st.enab[`IPF_LO_W-1:0];
      `IPF_OFS_EN_HI:   d = {{(`IPF_DATA_W-`IPF_HI_W){1'b0}}, st.enab[`IPF_NSRC-1:`IPF_LO_W]};
      default:          d = d;
    endcase
    return d;
  endfunction

  localparam ipf_pkg::ipf_state_t RST_STATE = resetState();

  ipf_pkg::ipf_state_t state_q;
  ipf_pkg::ipf_state_t state_d;

  logic [`IPF_NSRC-1:0] pending;
  logic [`IPF_NSRC-1:0] clrVec;
  logic [`IPF_NSRC-1:0] enNext;

  genvar gi;
  generate
    for (gi = 0; gi < `IPF_NSRC; gi++) begin : g_src
      assign srcLevel[gi] = state_q.prio[srcSlot(gi)];
      // A zero level masks the source as firmly as a clear enable bit
      assign pending[gi]  = state_q.flag[gi] && state_q.enab[gi] &&
                            (state_q.prio[srcSlot(gi)] != `IPF_LEVEL_OFF);
    end
  endgenerate

  always_comb begin
    clrVec = '0;
    enNext = state_q.enab;
    if (wrStb) begin
      case (addr)
        `IPF_OFS_CLR_LO: clrVec[`IPF_LO_W-1:0] = wdata;
        `IPF_OFS_CLR_HI: clrVec[`IPF_NSRC-1:`IPF_LO_W] = wdata[`IPF_HI_W-1:0];
        `IPF_OFS_EN_LO:  enNext[`IPF_LO_W-1:0] = wdata;
        `IPF_OFS_EN_HI:  enNext[`IPF_NSRC-1:`IPF_LO_W] = wdata[`IPF_HI_W-1:0];
        default: begin
          clrVec = '0;
        end
      endcase
    end
  end

  always_comb begin
    logic [`IPF_NSLOT-1:0] impl;
    logic [`IPF_LVL_W-1:0] best;
    impl = `IPF_SLOT_IMPL;
    best = `IPF_LEVEL_OFF;
    state_d = state_q;
    if (ce) begin
      // Read data stand for exactly the cycle after the strobe
      state_d.rdata = rdStb ? readMux(state_q, addr) : '0;
      for (int s = 0; s < `IPF_NSLOT; s++) begin
        if (wrStb && impl[s] && addr == slotReg(s)) begin
          state_d.prio[s] = wdata[slotPos(s) +: `IPF_LVL_W];
        end
      end
      state_d.enab = enNext;
      // New event beats a simultaneous clear so no request is lost
      state_d.flag = (state_q.flag & ~clrVec) | srcEvent;
      state_d.grant = '0;
      // Strict compare: on equal levels the lower source index wins
      for (int i = 0; i < `IPF_NSRC; i++) begin
        if (pending[i] && srcLevel[i] > best) begin
          best = srcLevel[i];
          state_d.grant.valid = 1'b1;
          state_d.grant.src   = `IPF_SRC_W'(i);
          state_d.grant.level = srcLevel[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= RST_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata  = state_q.rdata;
  assign grant  = state_q.grant;
  assign irqOut = |pending;

  // Checks

  reset_level_a: assert property (
    @(posedge clk_sys)
    (nrst && !$past(nrst)) |-> (srcLevel == {`IPF_NSRC{`IPF_RST_LEVEL}}))
    else $error("priority level not 4 after reset");

  gap_bits_zero_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ($past(ce && rdStb) && $past(addr) >= `IPF_OFS_PRIO2 && $past(addr) <= `IPF_OFS_PRIO7)
    |-> (rdata[15] == 1'b0 && rdata[11] == 1'b0 && rdata[7] == 1'b0 && rdata[3] == 1'b0))
    else $error("unimplemented priority bit reads one");

  write_readback_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO2)
    ##1 (ce && rdStb && addr == `IPF_OFS_PRIO2)
    |=> (rdata == ($past(wdata, 2) & 16'h7777)))
    else $error("priority register 2 read back differs");

  unused_drop_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO4)
    ##1 (ce && rdStb && addr == `IPF_OFS_PRIO4)
    |=> (rdata[11:7] == 5'h00 && rdata[14:12] == $past(wdata[14:12], 2)))
    else $error("write reached unused bits of register 4");

  zero_never_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    grant.valid |-> (grant.level != `IPF_LEVEL_OFF))
    else $error("disabled source granted");

  enable_gate_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ($past(ce) && grant.valid)
    |-> ((($past(state_q.enab & state_q.flag) >> grant.src) & `IPF_NSRC'(1)) != '0))
    else $error("grant to source without enable");

  top_level_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && pending[ipf_pkg::SRC_TIMER3] && srcLevel[ipf_pkg::SRC_TIMER3] == `IPF_LEVEL_MAX)
    |=> (grant.valid && grant.level == `IPF_LEVEL_MAX && grant.src == ipf_pkg::SRC_TIMER3))
    else $error("level 7 at lowest index not granted");

  rank_order_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && pending[ipf_pkg::SRC_TIMER3] && pending[ipf_pkg::SRC_UART2_TRANSMIT] &&
     srcLevel[ipf_pkg::SRC_UART2_TRANSMIT] > srcLevel[ipf_pkg::SRC_TIMER3])
    |=> (grant.src != ipf_pkg::SRC_TIMER3))
    else $error("lower level won arbitration");

  min_level_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO2 && wdata[2:0] == `IPF_LEVEL_MIN)
    |=> (srcLevel[ipf_pkg::SRC_TIMER3] == `IPF_LEVEL_MIN))
    else $error("code 001 did not give level 1");

  event_wins_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && srcEvent != '0) |=> ((state_q.flag & $past(srcEvent)) == $past(srcEvent)))
    else $error("event lost against clear");

  irq_level_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    irqOut |-> ((state_q.flag & state_q.enab) != '0))
    else $error("interrupt raised with no enabled flag");

  reg2_place_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO2)
    |=> (srcLevel[ipf_pkg::SRC_UART1_RECEIVE] == $past(wdata[`IPF_FLD_HI -: 3]) &&
         srcLevel[ipf_pkg::SRC_SPI1_ERROR] == $past(wdata[`IPF_FLD_MID_LO -: 3])))
    else $error("register 2 field placement wrong");

  reg3_place_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO3)
    |=> (srcLevel[ipf_pkg::SRC_DMA1_DONE] == $past(wdata[`IPF_FLD_MID_HI -: 3]) &&
         srcLevel[ipf_pkg::SRC_UART1_TRANSMIT] == $past(wdata[`IPF_FLD_LO -: 3])))
    else $error("register 3 field placement wrong");

  reg4_place_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO4)
    |=> (srcLevel[ipf_pkg::SRC_CHANGE_NOTIFY] == $past(wdata[`IPF_FLD_HI -: 3]) &&
         srcLevel[ipf_pkg::SRC_I2C1_MASTER] == $past(wdata[`IPF_FLD_MID_LO -: 3])))
    else $error("register 4 field placement wrong");

  reg5_place_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO5)
    |=> (srcLevel[ipf_pkg::SRC_CAPTURE8] == $past(wdata[`IPF_FLD_HI -: 3]) &&
         srcLevel[ipf_pkg::SRC_EXT_IRQ1] == $past(wdata[`IPF_FLD_LO -: 3])))
    else $error("register 5 field placement wrong");

  reg6_place_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO6)
    |=> (srcLevel[ipf_pkg::SRC_TIMER4] == $past(wdata[`IPF_FLD_HI -: 3]) &&
         srcLevel[ipf_pkg::SRC_COMPARE3] == $past(wdata[`IPF_FLD_MID_LO -: 3])))
    else $error("register 6 field placement wrong");

  reg7_place_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO7)
    |=> (srcLevel[ipf_pkg::SRC_UART2_TRANSMIT] == $past(wdata[`IPF_FLD_HI -: 3]) &&
         srcLevel[ipf_pkg::SRC_UART2_RECEIVE] == $past(wdata[`IPF_FLD_MID_HI -: 3])))
    else $error("register 7 field placement wrong");

  max_code_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO7 && wdata[2:0] == `IPF_LEVEL_MAX)
    |=> (srcLevel[ipf_pkg::SRC_TIMER5] == `IPF_LEVEL_MAX))
    else $error("code 111 did not give level 7");

  zero_masks_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && srcLevel[ipf_pkg::SRC_TIMER3] == `IPF_LEVEL_OFF)
    |=> !(grant.valid && grant.src == ipf_pkg::SRC_TIMER3))
    else $error("source at level 0 granted");

  grant_idle_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && pending == '0) |=> !grant.valid)
    else $error("grant with nothing pending");

  irq_rises_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q.flag[ipf_pkg::SRC_TIMER3] && state_q.enab[ipf_pkg::SRC_TIMER3] &&
     srcLevel[ipf_pkg::SRC_TIMER3] != `IPF_LEVEL_OFF) |-> irqOut)
    else $error("enabled pending source gave no interrupt");

  enable_write_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_EN_HI)
    |=> (state_q.enab[`IPF_NSRC-1:`IPF_LO_W] == $past(wdata[`IPF_HI_W-1:0])))
    else $error("enable write did not land");

  enable_read_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && rdStb && addr == `IPF_OFS_EN_LO)
    |=> (rdata == $past(state_q.enab[`IPF_LO_W-1:0])))
    else $error("enable read back differs");

  // Clear only matters when no event for the same bit arrives alongside it
  clear_drop_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_CLR_LO && wdata[0] && !srcEvent[ipf_pkg::SRC_TIMER3])
    |=> !state_q.flag[ipf_pkg::SRC_TIMER3])
    else $error("clear did not drop flag");

  status_read_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && rdStb && addr == `IPF_OFS_STAT_LO)
    |=> (rdata == $past(state_q.flag[`IPF_LO_W-1:0])))
    else $error("status read differs from flags");

  status_pad_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && rdStb && addr == `IPF_OFS_STAT_HI)
    |=> (rdata[`IPF_DATA_W-1:`IPF_HI_W] == '0))
    else $error("status high register pad bits set");

  clear_reads_zero_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && rdStb && (addr == `IPF_OFS_CLR_LO || addr == `IPF_OFS_CLR_HI))
    |=> (rdata == '0))
    else $error("clear register read not zero");

  // Read data must not linger, or software polling would see stale values
  read_gap_zero_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ($past(ce) && !$past(rdStb)) |-> (rdata == '0))
    else $error("read data stands beyond one cycle");

  freeze_hold_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !ce |=> (state_q == $past(state_q)))
    else $error("state moved while clock enable low");

  field_width_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && wrStb && addr == `IPF_OFS_PRIO5)
    |=> (srcLevel[ipf_pkg::SRC_CAPTURE7] == $past(wdata[`IPF_FLD_MID_HI -: 3]) &&
         srcLevel[ipf_pkg::SRC_ADC2_DONE] == $past(wdata[`IPF_FLD_MID_LO -: 3])))
    else $error("register 5 middle fields wrong");

endmodule // ipf_priority_fields

/* File: ipf_src_model.sv */
// Behavioural model of the peripheral event sources feeding the priority block
`timescale 1ns/1ps
`include "ipf_defines.svh"

module ipf_src_model (
  input  wire logic                 clk_sys,
  output logic [`IPF_NSRC-1:0]      srcEvent
);
  initial srcEvent = '0;

  // One-cycle pulses only; a held event would keep re-setting the flag after a clear
  task automatic pulse(input logic [`IPF_NSRC-1:0] m);
    @(posedge clk_sys);
    srcEvent <= m;
    @(posedge clk_sys);
    srcEvent <= '0;
  endtask
endmodule // ipf_src_model

/* File: tb.sv */
// Self-checking bench for the interrupt priority field block
`timescale 1ns/1ps
`include "ipf_defines.svh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
  typedef struct {logic [3:0] a; logic [15:0] w; logic [15:0] r;} ipf_row_t;
  logic                       clk_sys;
  logic                       nrst;
  logic                       ce;
  logic                       wrStb;
  logic                       rdStb;
  logic                       irqOut;
  logic [`IPF_ADDR_W-1:0]     addr;
  logic [`IPF_DATA_W-1:0]     wdata;
  logic [`IPF_DATA_W-1:0]     rdata;
  logic [`IPF_DATA_W-1:0]     rdVal;
  logic [`IPF_DATA_W-1:0]     prv [16];
  logic [`IPF_NSRC-1:0]       srcEvent;
  ipf_pkg::ipf_levels_t       srcLevel;
  ipf_pkg::ipf_grant_t        grant;
  int                         errors;
  int                         totalChecks;
  ipf_row_t rows [15] = '{
    '{4'h2, 16'hFFFF, 16'h7777}, '{4'h3, 16'hFFFF, 16'h0777}, '{4'h4, 16'hFFFF, 16'h7077},
    '{4'h5, 16'hFFFF, 16'h7777}, '{4'h6, 16'hFFFF, 16'h7777}, '{4'h7, 16'hFFFF, 16'h7777},
    '{4'h2, 16'h7531, 16'h7531}, '{4'h3, 16'h7531, 16'h0531}, '{4'h4, 16'h7531, 16'h7031},
    '{4'h5, 16'h1357, 16'h1357}, '{4'h6, 16'h2460, 16'h2460}, '{4'h7, 16'h0246, 16'h0246},
    '{4'hF, 16'hFFFF, 16'h0000}, '{4'hA, 16'hFFFF, 16'h0000}, '{4'h0, 16'h1234, 16'h0000}};

  ipf_priority_fields i_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .srcEvent(srcEvent), .srcLevel(srcLevel),
    .grant(grant), .irqOut(irqOut));
  ipf_src_model i_src (.clk_sys(clk_sys), .srcEvent(srcEvent));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] impl(input int r);
    return (r == 3) ? 16'h0777 : (r == 4) ? 16'h7077 : 16'h7777;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wrStb <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wrStb <= 1'b0;
  endtask

  // Read data stands for one cycle only, so it is sampled just after the taking edge
  task automatic rdr(input logic [3:0] a);
    @(posedge clk_sys);
    rdStb <= 1'b1;
    addr  <= a;
    @(posedge clk_sys);
    rdStb <= 1'b0;
    #1;
    rdVal = rdata;
  endtask

  // Write then read with no gap, so the read-back checks see both together
  task automatic wrRd(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wrStb <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wrStb <= 1'b0;
    rdStb <= 1'b1;
    @(posedge clk_sys);
    rdStb <= 1'b0;
    #1;
    rdVal = rdata;
  endtask

  // Flag lands one edge after the pulse, grant one edge later
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic end_of_test;
    if (errors == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end

  initial begin
    int sl;
    nrst = 1'b0;
    ce = 1'b1;
    wrStb = 1'b0;
    rdStb = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int s = 0; s < `IPF_NSRC; s++) `CHK(srcLevel[s], `IPF_RST_LEVEL)
    for (int r = 2; r < 8; r++) begin
      rdr(r[3:0]);
      `CHK(rdVal, impl(r) & 16'h4444)
    end
    foreach (rows[i]) begin
      wrRd(rows[i].a, rows[i].w);
      `CHK(rdVal, rows[i].r)
      prv[rows[i].a] = rows[i].r;
    end
    // Slots 7 and 10 have no source, so the source index skips them
    for (int s = 0; s < `IPF_NSRC; s++) begin
      sl = s + (s >= 7) + (s >= 9);
      `CHK(srcLevel[s], prv[2 + sl / 4][4 * (sl % 4) +: 3])
    end
    wr(4'hC, 16'hFFFF);
    wr(4'hD, 16'h003F);
    i_src.pulse(22'h008001);
    settle();
    `CHK(irqOut, 1'b1)
    `CHK(grant, {1'b1, 5'h0F, 3'h6})
    wr(4'h6, 16'h2400);
    settle();
    `CHK(grant, {1'b1, 5'h00, 3'h1})
    wr(4'hA, 16'h0001);
    settle();
    `CHK(irqOut, 1'b0)
    `CHK(grant.valid, 1'b0)
    rdr(4'h8);
    `CHK(rdVal, 16'h8000)
    wr(4'hC, 16'h0000);
    i_src.pulse(22'h000008);
    settle();
    `CHK(irqOut, 1'b0)
    wr(4'hC, 16'h0008);
    settle();
    `CHK(irqOut, 1'b1)
    `CHK(grant, {1'b1, 5'h03, 3'h7})
    wr(4'hA, 16'hFFFF);
    wr(4'h2, 16'h0550);
    wr(4'hC, 16'hFFFF);
    i_src.pulse(22'h000006);
    settle();
    `CHK(grant, {1'b1, 5'h01, 3'h5})
    wr(4'hA, 16'hFFFF);
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(4'h2, 16'h0000);
    @(posedge clk_sys);
    ce <= 1'b1;
    rdr(4'h2);
    `CHK(rdVal, 16'h0550)
    @(posedge clk_sys);
    nrst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK(srcLevel[3], 3'h4)
    `CHK(irqOut, 1'b0)
    @(posedge clk_sys);
    nrst <= 1'b1;
    rdr(4'h2);
    `CHK(rdVal, 16'h4444)
    wr(4'hC, 16'hFFFF);
    wr(4'hD, 16'h003F);
    wr(4'h2, 16'h0003);
    wr(4'h7, 16'h7000);
    i_src.pulse(22'h200001);
    settle();
    `CHK(grant, {1'b1, 5'h15, 3'h7})
    wr(4'h2, 16'h0007);
    settle();
    `CHK(grant, {1'b1, 5'h00, 3'h7})
    end_of_test();
  end
endmodule // tb
